// >>> design/eeprom_prot_pkg.sv
package eeprom_prot_pkg;
    // Instruction codes
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;
    localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
    // Array geometry
    localparam int ADDR_BITS = 13;
    localparam int ARRAY_BYTES = 8192;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_BITS = 5;
    localparam logic [12:0] QUARTER_BASE = 13'h1800;
    localparam logic [12:0] HALF_BASE = 13'h1000;
    // Status byte layout
    localparam int EN_BIT = 7;
    localparam int BLH_BIT = 3;
    localparam int BLL_BIT = 2;
    localparam int LATCH_BIT = 1;
    localparam int BUSY_BIT = 0;
    localparam logic [7:0] STATUS_BUSY_VALUE = 8'hff;
    localparam logic [2:0] NV_RESET = 3'h0;
    // Write cycle timing
    localparam int WRITE_TIME_NS = 5000000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 20;

    typedef enum logic [2:0] {
        PH_OPCODE = 3'h0,
        PH_ADDR_HI = 3'h1,
        PH_ADDR_LO = 3'h3,
        PH_DATA = 3'h2,
        PH_IGNORE = 3'h6
    } phase_t;

    typedef enum logic [2:0] {
        PEND_NONE, PEND_SET, PEND_CLEAR, PEND_STATUS, PEND_ARRAY
    } pend_t;

    typedef enum logic [1:0] {
        CYC_IDLE = 2'h0,
        CYC_COPY = 2'h1,
        CYC_WAIT = 2'h3
    } cyc_t;

    typedef struct packed {
        logic en;
        logic blh;
        logic bll;
    } nv_t;

    typedef struct packed {
        logic ready;
        logic busy;
        logic latch;
        nv_t nv;
    } lvl_t;

    typedef struct packed {
        phase_t phase;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] opcode;
        logic [12:0] addr;
        logic [7:0] tx;
        pend_t pend;
        logic frame_tgl;
        logic [31:0] mask;
        logic [7:0] st_data;
        lvl_t sync0;
        lvl_t sync1;
    } link_t;

    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] wp_s;
        logic cs_prev;
        logic wp_prev;
        pend_t pend_s0;
        pend_t pend_s1;
        logic tgl_s0;
        logic tgl_s1;
        logic last_tgl;
        cyc_t cyc;
        logic [19:0] timer;
        logic [4:0] idx;
        logic [7:0] page;
        pend_t cmd;
        logic [7:0] st;
        logic latch;
        logic ready;
        logic abort;
        nv_t nv;
    } sys_t;
endpackage

// >>> design/spi_eeprom_protect_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// R1: Output bit changes on falling clock only
// R2: Input bits captured on rising clock
// R3: Chip select high: output floats, idle
// R4: No operation before chip select falls
// R5: Pin low, enable set: status write refused
// R6: Pin falling mid-frame aborts status write
// R7: Enable clear: pin ignored for writes
// R8: Host moves pause only while clock low
// R9: Pause freezes sequence, resumes same bit
// R10: Eight-bit instruction register, MSB first
// R11: Host holds select, pause, pin steady
// R12: First rising edge samples; clock may stop
// R13: Set/clear latch opcodes; writes need latch
// R14: Latch clears at reset and write end
// R15: Status readable always, even while busy
// R16: Status layout; only bits 7,3,2 writable
// R17: Busy flag; whole byte ones when busy
// R18: Latch flag mirrors the write latch
// R19: Lock bits select protected address range
// R20: Status read and array read opcodes
// R21: Status write and page write opcodes
// R22: Writability by latch, lock, pin, enable
// R23: Sixteen-bit address, low thirteen used
// R24: Read address increments, wraps at top
// R25: Page buffer wraps within 32 bytes
// R26: Write starts only on byte-aligned deselect
// R27: Self-timed cycle ends busy and latch
module spi_eeprom_protect_ctrl #(
    parameter int WRITE_CYCLES = eeprom_prot_pkg::WRITE_CYCLES
) (
    // System side
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Serial link
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_n_o,
    // Status
    output logic busy_o
);

    // Timer width bounds the self-timed cycle
    if (WRITE_CYCLES < 1 || WRITE_CYCLES >= 2 ** eeprom_prot_pkg::TIMER_W) begin : g_bad_cycles
        $error("WRITE_CYCLES out of range");
    end

    eeprom_prot_pkg::link_t link_q, link_d, cur;
    eeprom_prot_pkg::sys_t sys_q, sys_d;
    logic [7:0] page_q [eeprom_prot_pkg::PAGE_BYTES];
    logic [7:0] cell_q [eeprom_prot_pkg::ARRAY_BYTES];
    logic in_frame_q;
    logic frame_rst;
    logic so_q;
    logic drive_q;
    logic [7:0] sh;
    logic byte_done;
    logic page_we;
    logic [12:0] full_addr;
    logic [12:0] cell_addr;
    logic cell_we;
    logic cs_rise;
    logic wp_fall;
    logic status_ok;

    // Lock decode shared by the copy engine and its checks
    function automatic logic locked(input logic [12:0] a, input eeprom_prot_pkg::nv_t nv);
        logic hit;
        hit = 1'b0;
        unique case ({nv.blh, nv.bll})
            2'b00: hit = 1'b0;
            2'b01: hit = a >= eeprom_prot_pkg::QUARTER_BASE;
            2'b10: hit = a >= eeprom_prot_pkg::HALF_BASE;
            2'b11: hit = 1'b1;
        endcase
        return hit; // R19
    endfunction

    // Status byte as seen by the reader; all ones while busy
    function automatic logic [7:0] status_byte(input eeprom_prot_pkg::lvl_t l);
        logic [7:0] s;
        s = 8'h00;
        s[eeprom_prot_pkg::EN_BIT] = l.nv.en; // R16
        s[eeprom_prot_pkg::BLH_BIT] = l.nv.blh;
        s[eeprom_prot_pkg::BLL_BIT] = l.nv.bll;
        s[eeprom_prot_pkg::LATCH_BIT] = l.latch; // R18
        s[eeprom_prot_pkg::BUSY_BIT] = l.busy;
        if (l.busy)
            s = eeprom_prot_pkg::STATUS_BUSY_VALUE; // R17
        return s;
    endfunction

    // Frame marker: cleared while deselected, so the first edge restarts
    assign frame_rst = cs_n_i | sys_rst_i;

    always_ff @(posedge sck_i or posedge frame_rst)
    begin
        if (frame_rst)
            in_frame_q <= 1'b0;
        else if (hold_n_i)
            in_frame_q <= 1'b1; // R12
    end

    // Link next state; pause is sampled directly since it moves only while the clock is low
    always_comb
    begin
        cur = link_q;
        if (!in_frame_q)
        begin
            cur.phase = eeprom_prot_pkg::PH_OPCODE; // R12
            cur.bit_cnt = 3'h0;
            cur.pend = eeprom_prot_pkg::PEND_NONE;
            cur.frame_tgl = ~link_q.frame_tgl;
        end
        link_d = cur;
        page_we = 1'b0;
        sh = {cur.shift[6:0], si_i}; // R2 R10
        byte_done = cur.bit_cnt == 3'h7;
        full_addr = {cur.addr[12:8], sh};
        link_d.shift = sh;
        link_d.bit_cnt = cur.bit_cnt + 3'h1;
        link_d.sync0 = {sys_q.ready, sys_q.cyc != eeprom_prot_pkg::CYC_IDLE, sys_q.latch, sys_q.nv};
        link_d.sync1 = link_q.sync0;
        link_d.pend = eeprom_prot_pkg::PEND_NONE; // R26
        unique case (cur.phase)
            eeprom_prot_pkg::PH_OPCODE:
            begin
                if (byte_done)
                begin
                    link_d.opcode = sh; // R10
                    link_d.phase = eeprom_prot_pkg::PH_IGNORE;
                    // Only a status read is served while a write runs
                    if (link_q.sync1.ready && (sh == eeprom_prot_pkg::STATUS_READ_CMD
                        || !link_q.sync1.busy)) // R4 R15
                    begin
                        unique case (sh)
                            eeprom_prot_pkg::STATUS_READ_CMD:
                            begin
                                link_d.phase = eeprom_prot_pkg::PH_DATA; // R20
                                link_d.tx = status_byte(link_q.sync1);
                            end
                            eeprom_prot_pkg::ARRAY_READ_CMD, eeprom_prot_pkg::ARRAY_WRITE_CMD:
                            begin
                                link_d.phase = eeprom_prot_pkg::PH_ADDR_HI; // R20 R21
                                link_d.mask = 32'h0;
                            end
                            eeprom_prot_pkg::STATUS_WRITE_CMD:
                                link_d.phase = eeprom_prot_pkg::PH_DATA; // R21
                            eeprom_prot_pkg::SET_WRITE_LATCH_CMD:
                                link_d.pend = eeprom_prot_pkg::PEND_SET; // R13
                            eeprom_prot_pkg::CLEAR_WRITE_LATCH_CMD:
                                link_d.pend = eeprom_prot_pkg::PEND_CLEAR; // R13
                            default:
                                link_d.phase = eeprom_prot_pkg::PH_IGNORE;
                        endcase
                    end
                end
            end
            eeprom_prot_pkg::PH_ADDR_HI:
            begin
                if (byte_done)
                begin
                    link_d.addr[12:8] = sh[4:0]; // R23
                    link_d.phase = eeprom_prot_pkg::PH_ADDR_LO;
                end
            end
            eeprom_prot_pkg::PH_ADDR_LO:
            begin
                if (byte_done)
                begin
                    link_d.addr = full_addr;
                    link_d.phase = eeprom_prot_pkg::PH_DATA;
                    link_d.tx = cell_q[full_addr]; // R20
                end
            end
            eeprom_prot_pkg::PH_DATA:
            begin
                if (byte_done)
                begin
                    unique case (cur.opcode)
                        eeprom_prot_pkg::ARRAY_READ_CMD:
                        begin
                            link_d.addr = cur.addr + 13'h1; // R24
                            link_d.tx = cell_q[cur.addr + 13'h1];
                        end
                        eeprom_prot_pkg::STATUS_READ_CMD:
                            link_d.tx = status_byte(link_q.sync1); // R15
                        eeprom_prot_pkg::STATUS_WRITE_CMD:
                        begin
                            link_d.st_data = sh;
                            link_d.pend = eeprom_prot_pkg::PEND_STATUS; // R26
                        end
                        default:
                        begin
                            page_we = 1'b1; // R25
                            link_d.mask[cur.addr[4:0]] = 1'b1;
                            link_d.addr[4:0] = cur.addr[4:0] + 5'h1;
                            link_d.pend = eeprom_prot_pkg::PEND_ARRAY; // R26
                        end
                    endcase
                end
            end
            default:
                link_d.phase = eeprom_prot_pkg::PH_IGNORE;
        endcase
        if (!hold_n_i)
            link_d = link_q; // R9
    end

    // Link state on the serial clock
    always_ff @(posedge sck_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            link_q <= '0;
        else
            link_q <= link_d;
    end

    // Page buffer; only the copy engine reads it, after deselect
    always_ff @(posedge sck_i)
    begin
        if (page_we && hold_n_i)
            page_q[cur.addr[4:0]] <= sh; // R25
    end

    // Output shifts on the falling edge so the host samples a settled bit
    always_ff @(negedge sck_i or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            so_q <= 1'b0;
            drive_q <= 1'b0; // R3
        end
        else if (hold_n_i)
        begin
            so_q <= link_q.tx[3'h7 - link_q.bit_cnt]; // R1
            drive_q <= in_frame_q && link_q.phase == eeprom_prot_pkg::PH_DATA
                && (link_q.opcode == eeprom_prot_pkg::ARRAY_READ_CMD
                || link_q.opcode == eeprom_prot_pkg::STATUS_READ_CMD);
        end
    end

    // Output floats when deselected or paused
    assign so_o = so_q;
    assign so_oe_n_o = cs_n_i | ~hold_n_i | ~drive_q; // R3

    // System-side edges of the synchronised pins
    assign cs_rise = sys_q.cs_s[1] & ~sys_q.cs_prev;
    assign wp_fall = ~sys_q.wp_s[1] & sys_q.wp_prev;
    assign status_ok = sys_q.latch && !sys_q.abort && !(sys_q.nv.en && !sys_q.wp_s[1]);
    assign cell_addr = {sys_q.page, sys_q.idx};
    assign cell_we = sys_q.cyc == eeprom_prot_pkg::CYC_COPY && link_q.mask[sys_q.idx]
        && !locked(cell_addr, sys_q.nv);

    // Write engine; commands are acted on at deselect, when link state is still
    always_comb
    begin
        sys_d = sys_q;
        sys_d.cs_s = {sys_q.cs_s[0], cs_n_i};
        sys_d.wp_s = {sys_q.wp_s[0], wp_n_i};
        sys_d.cs_prev = sys_q.cs_s[1];
        sys_d.wp_prev = sys_q.wp_s[1];
        sys_d.pend_s0 = link_q.pend;
        sys_d.pend_s1 = sys_q.pend_s0;
        sys_d.tgl_s0 = link_q.frame_tgl;
        sys_d.tgl_s1 = sys_q.tgl_s0;
        if (sys_q.cs_s[1])
            sys_d.ready = 1'b1; // R4
        if (!sys_q.cs_s[1] && sys_q.cs_prev)
            sys_d.abort = 1'b0;
        if (!sys_q.cs_s[1] && wp_fall && sys_q.nv.en)
            sys_d.abort = 1'b1; // R6 R7
        if (cs_rise)
            sys_d.last_tgl = sys_q.tgl_s1;
        unique case (sys_q.cyc)
            eeprom_prot_pkg::CYC_IDLE:
            begin
                if (cs_rise && sys_q.ready && sys_q.tgl_s1 != sys_q.last_tgl)
                begin
                    sys_d.cmd = sys_q.pend_s1;
                    sys_d.timer = '0;
                    sys_d.idx = 5'h0;
                    sys_d.page = link_q.addr[12:5];
                    sys_d.st = link_q.st_data;
                    unique case (sys_q.pend_s1)
                        eeprom_prot_pkg::PEND_SET: sys_d.latch = 1'b1; // R13
                        eeprom_prot_pkg::PEND_CLEAR: sys_d.latch = 1'b0; // R13
                        eeprom_prot_pkg::PEND_STATUS:
                            if (status_ok)
                                sys_d.cyc = eeprom_prot_pkg::CYC_WAIT; // R5 R22
                        eeprom_prot_pkg::PEND_ARRAY:
                            if (sys_q.latch)
                                sys_d.cyc = eeprom_prot_pkg::CYC_COPY; // R22
                        default:
                            sys_d.cmd = eeprom_prot_pkg::PEND_NONE;
                    endcase
                end
            end
            eeprom_prot_pkg::CYC_COPY:
            begin
                sys_d.idx = sys_q.idx + 5'h1;
                if (sys_q.idx == 5'h1f)
                    sys_d.cyc = eeprom_prot_pkg::CYC_WAIT;
            end
            eeprom_prot_pkg::CYC_WAIT:
            begin
                sys_d.timer = sys_q.timer + 20'h1;
                if (sys_q.timer == eeprom_prot_pkg::TIMER_W'(WRITE_CYCLES - 1))
                begin
                    sys_d.cyc = eeprom_prot_pkg::CYC_IDLE; // R27
                    sys_d.latch = 1'b0; // R14
                    if (sys_q.cmd == eeprom_prot_pkg::PEND_STATUS)
                        sys_d.nv = {sys_q.st[eeprom_prot_pkg::EN_BIT],
                            sys_q.st[eeprom_prot_pkg::BLH_BIT],
                            sys_q.st[eeprom_prot_pkg::BLL_BIT]}; // R16
                end
            end
            default:
                sys_d.cyc = eeprom_prot_pkg::CYC_IDLE;
        endcase
    end

    // System state; latch and lock bits start clear
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            // Select history starts low: frames count only once select is seen high
            sys_q <= '0; // R4 R14
            sys_q.nv <= eeprom_prot_pkg::NV_RESET;
        end
        else
        begin
            sys_q <= sys_d;
        end
    end

    // Cell array, written one byte per clock during the copy
    always_ff @(posedge clk_i)
    begin
        if (cell_we)
            cell_q[cell_addr] <= page_q[sys_q.idx]; // R19 R22
    end

    assign busy_o = sys_q.cyc != eeprom_prot_pkg::CYC_IDLE;

    // System-domain checks
    chk_latch_before_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R13
        $rose(busy_o) |-> $past(sys_q.latch)) else $error("write began without latch");
    chk_latch_end_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R14
        $fell(busy_o) |-> !sys_q.latch) else $error("latch left set after write");
    chk_pin_blocks_status: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R5
        ($rose(busy_o) && sys_q.cmd == eeprom_prot_pkg::PEND_STATUS)
        |-> !$past(sys_q.nv.en && !sys_q.wp_s[1])) else $error("status write while pin low");
    chk_abort_blocks: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R6
        ($rose(busy_o) && sys_q.cmd == eeprom_prot_pkg::PEND_STATUS) |-> !$past(sys_q.abort))
        else $error("aborted status write ran");
    chk_pin_ignored: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
        (!busy_o && cs_rise && sys_q.ready && sys_q.tgl_s1 != sys_q.last_tgl && sys_q.latch
        && sys_q.pend_s1 == eeprom_prot_pkg::PEND_STATUS && !sys_q.nv.en && !sys_q.abort)
        |=> sys_q.cyc == eeprom_prot_pkg::CYC_WAIT) else $error("status write refused");
    chk_ready_first: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R4
        !sys_q.ready |-> (!busy_o && !sys_q.latch)) else $error("acted before select seen");
    chk_lock_respected: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R19
        cell_we |-> !locked(cell_addr, sys_q.nv)) else $error("locked cell written");
    chk_copy_to_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R25
        (sys_q.cyc == eeprom_prot_pkg::CYC_COPY && sys_q.idx == 5'h1f)
        |=> sys_q.cyc == eeprom_prot_pkg::CYC_WAIT) else $error("page copy length wrong");
    chk_wait_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R27
        sys_q.cyc == eeprom_prot_pkg::CYC_WAIT |-> sys_q.timer < WRITE_CYCLES)
        else $error("write cycle overran");

    // Link-domain checks
    chk_busy_all_ones: assert property (@(posedge sck_i) disable iff (sys_rst_i) // R17
        (hold_n_i && cur.phase == eeprom_prot_pkg::PH_OPCODE && byte_done
        && sh == eeprom_prot_pkg::STATUS_READ_CMD && link_q.sync1.ready && link_q.sync1.busy)
        |=> link_q.tx == eeprom_prot_pkg::STATUS_BUSY_VALUE) else $error("busy status not ones");
    chk_read_advance: assert property (@(posedge sck_i) disable iff (sys_rst_i) // R24
        (hold_n_i && in_frame_q && link_q.phase == eeprom_prot_pkg::PH_DATA && byte_done
        && link_q.opcode == eeprom_prot_pkg::ARRAY_READ_CMD)
        |=> link_q.addr == $past(link_q.addr) + 13'h1) else $error("read address stuck");
    chk_pause_freeze: assert property (@(posedge sck_i) disable iff (sys_rst_i) // R9
        !hold_n_i |=> $stable(link_q)) else $error("state moved during pause");

endmodule // spi_eeprom_protect_ctrl

// >>> sim/host_spi_model.sv
`timescale 1ns/100ps
// Host SPI master in mode 0; its clock rests low outside frames
module host_spi_model (
    // Serial link
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    output logic hold_n_o,
    input wire logic so_i,
    input wire logic so_oe_n_i
);
    logic [7:0] tx [0:4];
    logic [7:0] rx [0:4];
    initial
    begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        hold_n_o = 1'b1;
    end
    // One frame; a pause with a stray clock pulse is taken before bit pause_at
    task run(input int nbits, input int pause_at);
        int i;
        begin
            cs_n_o = 1'b0;
            #20;
            for (i = 0; i < nbits; i++)
            begin
                if (i == pause_at)
                begin
                    hold_n_o = 1'b0;
                    si_o = ~si_o;
                    #15 sck_o = 1'b1;
                    #15 sck_o = 1'b0;
                    #15 hold_n_o = 1'b1;
                end
                si_o = tx[i / 8][7 - i % 8];
                #15 sck_o = 1'b1;
                rx[i / 8][7 - i % 8] = so_oe_n_i ? ~so_i : so_i; // Floating reads wrong
                #15 sck_o = 1'b0;
            end
            #20 cs_n_o = 1'b1;
            si_o = ~si_o; // Released line shows no stale data
            #100;
        end
    endtask
endmodule // host_spi_model

// >>> sim/spi_eeprom_protect_ctrl_tb.sv
`timescale 1ns/100ps
module spi_eeprom_protect_ctrl_tb;
    typedef struct packed {logic [7:0] wr; logic wp_n; logic [7:0] exp;} row_t;
    // Status write value, pin level, status expected afterwards
    row_t rows [0:4] = '{'{8'hfc, 1'b1, 8'h8c}, '{8'h04, 1'b0, 8'h8e},
        '{8'h04, 1'b1, 8'h04}, '{8'h0c, 1'b0, 8'h0c}, '{8'h00, 1'b0, 8'h00}};
    logic clk_i, sys_rst_i, wp_n_i, sck, cs_n, si, hold_n, so, so_oe_n, busy_o;
    int n_mismatch = 0;
    int compares = 0;
    int k;
    spi_eeprom_protect_ctrl #(.WRITE_CYCLES(60)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i),
        .so_o(so), .so_oe_n_o(so_oe_n), .busy_o(busy_o));
    host_spi_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
        .so_i(so), .so_oe_n_i(so_oe_n));
    task give_verdict;
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task check(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Loads up to five bytes into the host and sends nbits of them
    task frame(input logic [39:0] v, input int nbits, input int pause_at);
        int i;
        for (i = 0; i < 5; i++)
            host.tx[i] = v[39 - 8 * i -: 8];
        host.run(nbits, pause_at);
    endtask
    // Waits for any self-timed cycle to end, bounded
    task settle;
        int i;
        for (i = 0; i < 300 && busy_o !== 1'b0; i++)
            @(posedge clk_i);
        check("busy", 8'h00, {7'h0, busy_o});
    endtask
    task rd_status(input logic [7:0] exp, input int pause_at);
        frame({eeprom_prot_pkg::STATUS_READ_CMD, 32'h0}, 16, pause_at);
        check("status", exp, host.rx[1]);
    endtask
    task wr_status(input logic [7:0] v);
        frame({eeprom_prot_pkg::SET_WRITE_LATCH_CMD, 32'h0}, 8, 99);
        frame({eeprom_prot_pkg::STATUS_WRITE_CMD, v, 24'h0}, 16, 99);
    endtask
    // Upper address bits set on purpose: only the low thirteen count
    task arr_wr(input logic [12:0] a, input int nbits, input logic [15:0] d);
        frame({eeprom_prot_pkg::SET_WRITE_LATCH_CMD, 32'h0}, 8, 99);
        frame({eeprom_prot_pkg::ARRAY_WRITE_CMD, 3'h7, a, d}, nbits, 99);
        settle;
    endtask
    task arr_rd(input logic [12:0] a, input logic [15:0] exp);
        frame({eeprom_prot_pkg::ARRAY_READ_CMD, 3'h5, a, 16'h0}, 40, 99);
        check("array data", exp, {host.rx[3], host.rx[4]});
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        #300000;
        n_mismatch++;
        give_verdict;
    end
    initial
    begin
        sys_rst_i = 1'b1;
        wp_n_i = 1'b1;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rd_status(8'h00, 3);
        for (k = 0; k < 5; k++)
        begin
            @(posedge clk_i);
            wp_n_i <= rows[k].wp_n;
            wr_status(rows[k].wr);
            settle;
            rd_status(rows[k].exp, 99);
        end
        // Status read while the write cycle runs
        wr_status(8'h00);
        for (k = 0; k < 50 && busy_o !== 1'b1; k++)
            @(posedge clk_i);
        rd_status(8'hff, 99);
        settle;
        rd_status(8'h00, 99);
        // Page wrap, read wrap at top of array, unaligned deselect
        arr_wr(13'h0000, 32, 16'h3c00);
        arr_wr(13'h1fe1, 32, 16'h3c00);
        arr_wr(13'h1fff, 40, 16'ha55a);
        arr_rd(13'h1fff, 16'ha53c);
        arr_rd(13'h1fe0, {8'h5a, 8'h3c});
        arr_wr(13'h0000, 36, 16'hc300);
        arr_rd(13'h1fff, 16'ha53c);
        // Upper half locked, lower half still writable
        wr_status(8'h08);
        settle;
        arr_wr(13'h1fff, 32, 16'h1100);
        arr_wr(13'h0000, 32, 16'h7700);
        arr_rd(13'h1fff, 16'ha577);
        // Latch cleared again before the write
        frame({eeprom_prot_pkg::SET_WRITE_LATCH_CMD, 32'h0}, 8, 99);
        frame({eeprom_prot_pkg::CLEAR_WRITE_LATCH_CMD, 32'h0}, 8, 99);
        frame({eeprom_prot_pkg::ARRAY_WRITE_CMD, 16'h0000, 8'h99, 8'h0}, 32, 99);
        settle;
        arr_rd(13'h1fff, 16'ha577);
        // Pin dips mid-frame with the enable set, then recovers: write dropped
        @(posedge clk_i);
        wp_n_i <= 1'b1;
        wr_status(8'h80);
        settle;
        fork
            wr_status(8'h0c);
            begin
                repeat (70) @(posedge clk_i);
                wp_n_i <= 1'b0;
                repeat (15) @(posedge clk_i);
                wp_n_i <= 1'b1;
            end
        join
        settle;
        rd_status(8'h82, 99);
        give_verdict;
    end
endmodule // spi_eeprom_protect_ctrl_tb
